// ===== rtl/mshc_pkg.sv
package mshc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] MSHC_OFF_CFG    = 12'h000;
  localparam logic [11:0] MSHC_OFF_HOLD   = 12'h004;
  localparam logic [11:0] MSHC_OFF_STATE  = 12'h008;
  localparam logic [11:0] MSHC_OFF_IRQST  = 12'h00C;
  localparam logic [11:0] MSHC_OFF_IRQMSK = 12'h010;
  localparam logic [11:0] MSHC_OFF_CTRL   = 12'h014;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int MSHC_CFG_BASIC_LSB = 0;
  localparam int MSHC_CFG_GRP2_LSB  = 4;
  localparam logic [1:0] MSHC_BASIC_RST = 2'h0;
  localparam logic MSHC_GRP2_RST = 1'b0;
  localparam logic [9:0] MSHC_HOLD_MIN = 10'd20;
  localparam logic [9:0] MSHC_HOLD_MAX = 10'd1000;
  localparam logic [9:0] MSHC_HOLD_RST = 10'd20;
  localparam int MSHC_NUM_IRQ = 4;
  localparam int MSHC_IRQ_STOP_DONE = 0;
  localparam int MSHC_IRQ_PWR_LOSS = 1;
  localparam int MSHC_IRQ_PWR_CUT = 2;
  localparam int MSHC_IRQ_PWR_BACK = 3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MSHC_CLK_HZ = 50000000;
  localparam int MSHC_TICK_MS = 1;
  localparam int MSHC_MS_CYCLES = MSHC_CLK_HZ / 1000 * MSHC_TICK_MS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MSHC_CTL_POSITION,
    MSHC_CTL_SPEED,
    MSHC_CTL_TORQUE
  } mshc_ctl_mode_t;

  typedef enum logic [1:0] {
    MSHC_HOW_DYN_BRAKE,
    MSHC_HOW_COAST,
    MSHC_HOW_ZERO_SPEED
  } mshc_stop_how_t;

  typedef struct packed {
    logic drive_en;
    logic dyn_brake;
    logic zero_speed;
    logic power_on;
  } mshc_stage_t;

endpackage

// ===== rtl/mshc_ms_timer.sv
`timescale 1ns/1ns
`default_nettype none
module mshc_ms_timer
  import mshc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic [10:0] ms_count_q
);

  logic [15:0] div_q;
  logic tick;

  assign tick = (div_q == 16'(MSHC_MS_CYCLES - 1));

  // ---------------------------------------------------------------
  // Millisecond divider
  // ---------------------------------------------------------------
  // clock cycles counted within the current outage millisecond
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (!run || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // The count saturates so a long outage never wraps back below the hold time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_count_q <= 11'h000;
    end else if (!run) begin
      ms_count_q <= 11'h000;
    end else if (tick && ms_count_q != 11'h7FF) begin
      ms_count_q <= ms_count_q + 11'h001;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/mshc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Basic selection 0: dynamic braking stop, then stay in dynamic brake.
// - Basic selection 1: dynamic braking stop, then coast.
// - Basic selection 2: coast to rest and stay coasting.
// - First group alarm stops like servo-off under basic selection.
// - Second group, selection 0: zero-speed stop; then brake if basic 0, else coast.
// - Second group, selection 1: stop exactly as basic selection says.
// - Second group selection used only in position and speed control.
// - Hold time 20 to 1000 ms, default 20, effective immediately.
// - Power back before hold time elapses keeps servo running.
// - Outage reaching hold time turns motor power off.
// - Undervoltage alarm during outage overrides the hold time.
// - Control supply loss acts as normal power-down, ignoring hold time.
// - Main power lost before servo-off: stop by dynamic braking.
module mshc_top
  import mshc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic servo_on_pin,
  input wire logic first_alarm_group_pin,
  input wire logic second_alarm_group_pin,
  input wire logic undervoltage_alarm_pin,
  input wire logic main_power_ok_pin,
  input wire logic control_power_ok_pin,
  input wire logic motor_stopped_pin,
  input wire mshc_ctl_mode_t ctl_mode,
  output mshc_stage_t stage_q,
  output logic irq
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_STOPPING,
    ST_HOLD_BRAKE,
    ST_COAST
  } mshc_state_t;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] clean_q;

  assign raw_in = {servo_on_pin, first_alarm_group_pin, second_alarm_group_pin,
                   undervoltage_alarm_pin, main_power_ok_pin,
                   control_power_ok_pin, motor_stopped_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          clean_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            clean_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic servo_on;
  logic alarm1;
  logic alarm2;
  logic uv_alarm;
  logic main_ok;
  logic ctrl_ok;
  logic stopped;
  assign {servo_on, alarm1, alarm2, uv_alarm, main_ok, ctrl_ok, stopped} = clean_q;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [1:0] basic_stop_selection_q;
  logic group_two_stop_selection_q;
  logic [1:0] basic_live_q;
  logic group_two_stop_selection_live_q;
  logic [9:0] power_cut_hold_time_q;
  logic [MSHC_NUM_IRQ-1:0] irq_status_q;
  logic [MSHC_NUM_IRQ-1:0] irq_mask_q;
  logic restart_req;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [MSHC_NUM_IRQ-1:0] irq_events;

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    is_reg = (a == off);
  endfunction

  assign addr_ok = is_reg(paddr, MSHC_OFF_CFG) || is_reg(paddr, MSHC_OFF_HOLD) ||
                   is_reg(paddr, MSHC_OFF_STATE) || is_reg(paddr, MSHC_OFF_IRQST) ||
                   is_reg(paddr, MSHC_OFF_IRQMSK) || is_reg(paddr, MSHC_OFF_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && penable && !pwrite;
  assign restart_req = wr_en && is_reg(paddr, MSHC_OFF_CTRL) && pwdata[0];

  // Software writes the live copies; the engine only sees them after restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_live_q <= MSHC_BASIC_RST;
      group_two_stop_selection_live_q <= MSHC_GRP2_RST;
    end else if (wr_en && is_reg(paddr, MSHC_OFF_CFG)) begin
      if (pwdata[MSHC_CFG_BASIC_LSB +: 2] != 2'h3) begin
        basic_live_q <= pwdata[MSHC_CFG_BASIC_LSB +: 2];
      end
      group_two_stop_selection_live_q <= pwdata[MSHC_CFG_GRP2_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_cut_hold_time_q <= MSHC_HOLD_RST;
    end else if (wr_en && is_reg(paddr, MSHC_OFF_HOLD)) begin
      if (pwdata[9:0] < MSHC_HOLD_MIN || pwdata[31:10] != 22'h0) begin
        power_cut_hold_time_q <= (pwdata[31:10] != 22'h0) ? MSHC_HOLD_MAX : MSHC_HOLD_MIN;
      end else if (pwdata[9:0] > MSHC_HOLD_MAX) begin
        power_cut_hold_time_q <= MSHC_HOLD_MAX;
      end else begin
        power_cut_hold_time_q <= pwdata[9:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_en && is_reg(paddr, MSHC_OFF_IRQMSK)) begin
      irq_mask_q <= pwdata[MSHC_NUM_IRQ-1:0];
    end
  end

  // A new event wins over a simultaneous write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_en && is_reg(paddr, MSHC_OFF_IRQST)) ?
                       pwdata[MSHC_NUM_IRQ-1:0] : '0)) | irq_events;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ---------------------------------------------------------------
  // Stop engine
  // ---------------------------------------------------------------
  mshc_state_t state_q;
  mshc_state_t state_d;
  mshc_stop_how_t how_q;
  mshc_stop_how_t how_d;
  logic after_brake_q;
  logic after_brake_d;
  logic outage_q;
  logic cut_event;
  logic [10:0] outage_ms;
  logic stop_cause;
  logic power_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_stop_selection_q <= MSHC_BASIC_RST;
      group_two_stop_selection_q <= MSHC_GRP2_RST;
    end else if (restart_req) begin
      basic_stop_selection_q <= basic_live_q;
      group_two_stop_selection_q <= group_two_stop_selection_live_q;
    end
  end

  mshc_ms_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(outage_q),
    .ms_count_q(outage_ms)
  );

  assign cut_event = outage_q && (outage_ms >= {1'b0, power_cut_hold_time_q});
  assign power_fault = cut_event || (outage_q && uv_alarm) || !ctrl_ok;
  assign stop_cause = !servo_on || alarm1 || alarm2 || power_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outage_q <= 1'b0;
    end else if (state_q != ST_RUN || main_ok) begin
      outage_q <= 1'b0;
    end else begin
      outage_q <= 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    how_d = how_q;
    after_brake_d = after_brake_q;
    unique case (state_q)
      ST_IDLE: begin
        if (servo_on && !alarm1 && !alarm2 && main_ok && ctrl_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_cause) begin
          state_d = ST_STOPPING;
          how_d = (basic_stop_selection_q == 2'h2) ? MSHC_HOW_COAST : MSHC_HOW_DYN_BRAKE;
          after_brake_d = (basic_stop_selection_q == 2'h0);
          if (alarm2 && !alarm1 && !power_fault && ctl_mode != MSHC_CTL_TORQUE) begin
            if (!group_two_stop_selection_q) begin
              how_d = MSHC_HOW_ZERO_SPEED;
            end
          end
          if (power_fault && servo_on) begin
            how_d = MSHC_HOW_DYN_BRAKE;
          end
        end
      end
      ST_STOPPING: begin
        if (stopped) begin
          state_d = after_brake_q ? ST_HOLD_BRAKE : ST_COAST;
        end
      end
      ST_HOLD_BRAKE, ST_COAST: begin
        if (servo_on && !alarm1 && !alarm2 && main_ok && ctrl_ok) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      how_q <= MSHC_HOW_DYN_BRAKE;
      after_brake_q <= 1'b1;
    end else begin
      state_q <= state_d;
      how_q <= how_d;
      after_brake_q <= after_brake_d;
    end
  end

  // ---------------------------------------------------------------
  // Power stage outputs and events
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= '{drive_en: 1'b0, dyn_brake: 1'b1, zero_speed: 1'b0, power_on: 1'b0};
    end else begin
      stage_q.drive_en <= (state_d == ST_RUN) ||
                          (state_d == ST_STOPPING && how_d == MSHC_HOW_ZERO_SPEED);
      stage_q.zero_speed <= (state_d == ST_STOPPING && how_d == MSHC_HOW_ZERO_SPEED);
      stage_q.dyn_brake <= (state_d == ST_IDLE) || (state_d == ST_HOLD_BRAKE) ||
                           (state_d == ST_STOPPING && how_d == MSHC_HOW_DYN_BRAKE);
      stage_q.power_on <= (state_d == ST_RUN) ||
                          (state_d == ST_STOPPING && how_d == MSHC_HOW_ZERO_SPEED);
    end
  end

  logic main_ok_d1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ok_d1_q <= 1'b0;
    end else begin
      main_ok_d1_q <= main_ok;
    end
  end

  always_comb begin
    irq_events = '0;
    irq_events[MSHC_IRQ_STOP_DONE] = (state_q == ST_STOPPING) && (state_d != ST_STOPPING);
    irq_events[MSHC_IRQ_PWR_LOSS] = main_ok_d1_q && !main_ok;
    irq_events[MSHC_IRQ_PWR_CUT] = (state_q == ST_RUN) && power_fault;
    irq_events[MSHC_IRQ_PWR_BACK] = outage_q && main_ok;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (is_reg(paddr, MSHC_OFF_CFG)) begin
        prdata[MSHC_CFG_BASIC_LSB +: 2] <= basic_live_q;
        prdata[MSHC_CFG_GRP2_LSB] <= group_two_stop_selection_live_q;
      end else if (is_reg(paddr, MSHC_OFF_HOLD)) begin
        prdata[9:0] <= power_cut_hold_time_q;
      end else if (is_reg(paddr, MSHC_OFF_STATE)) begin
        prdata <= {8'h00, 5'h00, outage_ms, 1'b0, state_q, 2'h0, how_q};
      end else if (is_reg(paddr, MSHC_OFF_IRQST)) begin
        prdata[MSHC_NUM_IRQ-1:0] <= irq_status_q;
      end else if (is_reg(paddr, MSHC_OFF_IRQMSK)) begin
        prdata[MSHC_NUM_IRQ-1:0] <= irq_mask_q;
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule
`default_nettype wire

// ===== testbench/mshc_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module mshc_checker
  import mshc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic servo_on_pin,
  input wire logic first_alarm_group_pin,
  input wire logic undervoltage_alarm_pin,
  input wire logic main_power_ok_pin,
  input wire logic control_power_ok_pin,
  input wire mshc_ctl_mode_t ctl_mode,
  input wire mshc_stage_t stage_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic running;
  logic mapped;
  // Inputs pass a three-flop synchroniser, so stops are allowed twelve cycles.
  assign running = stage_q.drive_en && !stage_q.zero_speed;
  assign mapped = (paddr <= 12'h014) && (paddr[1:0] == 2'h0);
  a_pready_high:
  assert property (psel && penable |-> pready) else $error("pready low in access");
  a_slverr_unmapped:
  assert property (psel && penable && !mapped |-> pslverr) else $error("no error on hole");
  a_slverr_mapped:
  assert property (psel && penable && mapped |-> !pslverr) else $error("error on register");
  a_stop_servo_off:
  assert property ($fell(servo_on_pin) && running |-> ##[1:12] !running)
    else $error("servo off did not stop");
  a_stop_alarm_one:
  assert property ($rose(first_alarm_group_pin) && running |-> ##[1:12] !running)
    else $error("alarm did not stop");
  a_uv_overrides_hold:
  assert property ($rose(undervoltage_alarm_pin) && !main_power_ok_pin && running
    |-> ##[1:12] !running) else $error("undervoltage waited for hold time");
  a_ctrl_loss_stop:
  assert property ($fell(control_power_ok_pin) && running |-> ##[1:12] !running)
    else $error("control loss did not stop");
  a_one_stop_method:
  assert property (!(stage_q.dyn_brake && stage_q.zero_speed)) else $error("two methods");
  a_zero_not_torque:
  assert property ($rose(stage_q.zero_speed) |-> ctl_mode != MSHC_CTL_TORQUE)
    else $error("zero-speed stop in torque mode");
  c_zero_speed: cover property ($rose(stage_q.zero_speed));
  c_dyn_brake: cover property ($rose(stage_q.dyn_brake));
  c_refused: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// ===== testbench/mshc_motor_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Motor and power stage
// ------------------------------------------------------------
module mshc_motor_model
  import mshc_pkg::*;
#(
  parameter int STOP_CYCLES = 40
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mshc_stage_t stage_q,
  output logic motor_stopped_pin
);
  logic [7:0] spin_q;
  // The rotor runs down over a fixed span whenever it is not driven at speed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_q <= 8'h00;
    end else if (stage_q.drive_en && !stage_q.zero_speed) begin
      spin_q <= 8'h00;
    end else if (spin_q < 8'(STOP_CYCLES)) begin
      spin_q <= spin_q + 8'h01;
    end
  end
  assign motor_stopped_pin = (spin_q == 8'(STOP_CYCLES));
endmodule
`default_nettype wire

// ===== testbench/mshc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mshc_tb_top
  import mshc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic servo_on_pin, first_alarm_group_pin, second_alarm_group_pin, undervoltage_alarm_pin;
  logic main_power_ok_pin, control_power_ok_pin, motor_stopped_pin;
  mshc_ctl_mode_t ctl_mode;
  mshc_stage_t stage_q;
  int n_errors, n_tests;
  mshc_top u_mshc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .servo_on_pin, .first_alarm_group_pin, .second_alarm_group_pin,
    .undervoltage_alarm_pin, .main_power_ok_pin, .control_power_ok_pin, .motor_stopped_pin,
    .ctl_mode, .stage_q, .irq);
  mshc_motor_model u_mshc_motor_model (.pclk, .presetn, .stage_q, .motor_stopped_pin);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg_restart(input logic [31:0] v);
    apb(1'b1, MSHC_OFF_CFG, v);
    apb(1'b1, MSHC_OFF_CTRL, 32'h00000001);
  endtask
  task automatic start_run(input mshc_ctl_mode_t m);
    int n;
    ctl_mode <= m;
    servo_on_pin <= 1'b1;
    n = 0;
    while (!(stage_q.drive_en === 1'b1 && stage_q.zero_speed === 1'b0) && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("drive on", stage_q.drive_en, 1'b1);
    chk("power on", stage_q.power_on, 1'b1);
  endtask
  // Looks at the stop method first, then the state left once the motor rests.
  task automatic stop_chk(input logic db, input logic zs, input logic fin);
    int n;
    n = 0;
    while (stage_q.drive_en === 1'b1 && stage_q.zero_speed !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("stop brake", stage_q.dyn_brake, db);
    chk("stop zero", stage_q.zero_speed, zs);
    servo_on_pin <= 1'b0;
    first_alarm_group_pin <= 1'b0;
    second_alarm_group_pin <= 1'b0;
    undervoltage_alarm_pin <= 1'b0;
    main_power_ok_pin <= 1'b1;
    control_power_ok_pin <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, MSHC_OFF_IRQST, 32'h0);
      n++;
    end while (rd[MSHC_IRQ_STOP_DONE] !== 1'b1 && n < 100);
    chk("final brake", stage_q.dyn_brake, fin);
    chk("final drive", stage_q.drive_en, 1'b0);
    chk("final power", stage_q.power_on, 1'b0);
    apb(1'b1, MSHC_OFF_IRQST, 32'h0000000F);
  endtask
  task automatic stop_case(input logic [31:0] c, input mshc_ctl_mode_t m,
      input logic [2:0] cause, input logic db, input logic zs, input logic fin);
    cfg_restart(c);
    start_run(m);
    case (cause)
      3'h0: servo_on_pin <= 1'b0;
      3'h1: first_alarm_group_pin <= 1'b1;
      3'h2: second_alarm_group_pin <= 1'b1;
      3'h3: begin
        main_power_ok_pin <= 1'b0;
        undervoltage_alarm_pin <= 1'b1;
      end
      default: control_power_ok_pin <= 1'b0;
    endcase
    stop_chk(db, zs, fin);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    apb(1'b0, MSHC_OFF_CFG, 32'h0);
    chk("cfg default", {rd[4], rd[1:0]}, 3'h0);
    apb(1'b1, MSHC_OFF_CFG, 32'h00000003);
    apb(1'b0, MSHC_OFF_CFG, 32'h0);
    chk("basic 3 refused", rd[1:0], 2'h0);
    apb(1'b1, 12'h018, 32'h00000003);
    chk("hole refused", last_err, 1'b1);
  endtask
  task automatic t_hold();
    logic [9:0] w [4] = '{10'h005, 10'h3E8, 10'h3FF, 10'h013};
    logic [9:0] e [4] = '{10'h014, 10'h3E8, 10'h3E8, 10'h014};
    apb(1'b0, MSHC_OFF_HOLD, 32'h0);
    chk("hold default", rd[9:0], 10'h014);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, MSHC_OFF_HOLD, {22'h0, w[i]});
      apb(1'b0, MSHC_OFF_HOLD, 32'h0);
      chk("hold", rd[9:0], e[i]);
    end
  endtask
  task automatic t_stops();
    stop_case(32'h00, MSHC_CTL_POSITION, 3'h0, 1'b1, 1'b0, 1'b1);
    stop_case(32'h01, MSHC_CTL_SPEED, 3'h0, 1'b1, 1'b0, 1'b0);
    stop_case(32'h02, MSHC_CTL_POSITION, 3'h0, 1'b0, 1'b0, 1'b0);
    stop_case(32'h01, MSHC_CTL_POSITION, 3'h1, 1'b1, 1'b0, 1'b0);
    stop_case(32'h00, MSHC_CTL_POSITION, 3'h2, 1'b0, 1'b1, 1'b1);
    stop_case(32'h02, MSHC_CTL_SPEED, 3'h2, 1'b0, 1'b1, 1'b0);
    stop_case(32'h12, MSHC_CTL_POSITION, 3'h2, 1'b0, 1'b0, 1'b0);
    stop_case(32'h11, MSHC_CTL_SPEED, 3'h2, 1'b1, 1'b0, 1'b0);
    stop_case(32'h00, MSHC_CTL_TORQUE, 3'h2, 1'b1, 1'b0, 1'b1);
    stop_case(32'h02, MSHC_CTL_SPEED, 3'h3, 1'b1, 1'b0, 1'b0);
    stop_case(32'h01, MSHC_CTL_POSITION, 3'h4, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_late_cfg();
    cfg_restart(32'h0);
    apb(1'b1, MSHC_OFF_CFG, 32'h00000002);
    start_run(MSHC_CTL_POSITION);
    servo_on_pin <= 1'b0;
    stop_chk(1'b1, 1'b0, 1'b1);
  endtask
  task automatic t_outage();
    cfg_restart(32'h0);
    start_run(MSHC_CTL_SPEED);
    main_power_ok_pin <= 1'b0;
    // One millisecond is 50000 cycles; this outage spans a little over one.
    repeat (60000) @(posedge pclk);
    apb(1'b0, MSHC_OFF_STATE, 32'h0);
    chk("outage ms", rd[18:8], 11'h001);
    main_power_ok_pin <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("still driven", stage_q.drive_en, 1'b1);
    apb(1'b0, MSHC_OFF_IRQST, 32'h0);
    chk("loss and back", rd[3:0], 4'hA);
    apb(1'b1, MSHC_OFF_IRQMSK, 32'h0);
    #1;
    chk("irq masked", irq, 1'b0);
    apb(1'b1, MSHC_OFF_IRQMSK, 32'h0000000F);
    #1;
    chk("irq unmasked", irq, 1'b1);
    apb(1'b1, MSHC_OFF_IRQST, 32'h0000000A);
    #1;
    chk("irq clear", irq, 1'b0);
    servo_on_pin <= 1'b0;
    stop_chk(1'b1, 1'b0, 1'b1);
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {servo_on_pin, first_alarm_group_pin, second_alarm_group_pin} = 3'h0;
    undervoltage_alarm_pin = 1'b0;
    main_power_ok_pin = 1'b1;
    control_power_ok_pin = 1'b1;
    ctl_mode = MSHC_CTL_POSITION;
    repeat (16) @(posedge pclk);
    chk("reset stage", stage_q, 4'h4);
    presetn <= 1'b1;
    t_defaults();
    t_hold();
    t_stops();
    t_late_cfg();
    t_outage();
    summarize();
  end
  initial begin
    #1800000;
    n_errors++;
    summarize();
  end
endmodule
bind mshc_top mshc_checker u_mshc_checker (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .servo_on_pin, .first_alarm_group_pin, .undervoltage_alarm_pin,
  .main_power_ok_pin, .control_power_ok_pin, .ctl_mode, .stage_q);
`default_nettype wire
